// >>> sfb_pkg.sv
// shared constants, types and command decode for the serial flash bus front end
package sfb_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ3 = 8'h03;
  localparam logic [7:0] CMD_READ4 = 8'h13;
  localparam logic [7:0] CMD_FAST3 = 8'h0b;
  localparam logic [7:0] CMD_FAST4 = 8'h0c;
  localparam logic [7:0] CMD_QOUT3 = 8'h6b;
  localparam logic [7:0] CMD_QOUT4 = 8'h6c;
  localparam logic [7:0] CMD_QIO3 = 8'heb;
  localparam logic [7:0] CMD_QIO4 = 8'hec;
  localparam logic [7:0] CMD_QDDR3 = 8'hed;
  localparam logic [7:0] CMD_QDDR4 = 8'hee;
  localparam logic [7:0] CMD_PROG3 = 8'h02;
  localparam logic [7:0] CMD_PROG4 = 8'h12;
  localparam logic [7:0] CMD_QPROG3 = 8'h32;
  localparam logic [7:0] CMD_QPROG4 = 8'h34;
  localparam logic [7:0] CMD_XQPROG3 = 8'hc2;
  localparam logic [7:0] CMD_XQPROG4 = 8'h3e;
  localparam logic [7:0] CMD_WR_VCFG = 8'h81;
  localparam logic [7:0] CMD_FOUR_ON = 8'h38;
  localparam logic [7:0] CMD_FOUR_OFF = 8'hff;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_PDOWN = 8'hb9;
  localparam logic [7:0] CMD_PDOWN_EXIT = 8'hab;

  // ----------------------------------------------------------------
  // configuration byte 0
  // ----------------------------------------------------------------
  localparam logic [7:0] VCFG0_RST = 8'hff;
  localparam logic [7:0] VCFG0_DDR_A = 8'he7;
  localparam logic [7:0] VCFG0_DDR_B = 8'hc7;
  localparam int DQS_EN_BIT = 1;

  // ----------------------------------------------------------------
  // counts and timing
  // ----------------------------------------------------------------
  localparam logic [5:0] BYTE_BITS = 6'd8;
  localparam logic [5:0] ADDR3_BITS = 6'd24;
  localparam logic [5:0] ADDR4_BITS = 6'd32;
  localparam logic [5:0] DUMMY_CYC = 6'd8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_CLEAR_LOW_NS = 100;
  localparam logic [7:0] MIN_CLEAR_LOW_CYC =
    8'((MIN_CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_IN, ST_IGNORE} sfb_state_t;

  // pins that cross into the clk domain together
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic clear_n;
    logic [3:0] io;
  } sfb_pins_t;

  localparam sfb_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, clear_n: 1'b1, io: 4'h0};

  // shape of one command
  typedef struct packed {
    logic has_addr;
    logic addr4;
    logic quad_addr;
    logic quad_data;
    logic ddr;
    logic dummy;
    logic rd;
    logic wr;
  } sfb_cmd_t;

  // ----------------------------------------------------------------
  // decode of opcodes that carry an address
  // ----------------------------------------------------------------
  function automatic sfb_cmd_t sfb_decode(input logic [7:0] op);
    sfb_cmd_t c;
    c = '0;
    case (op)
      CMD_READ3, CMD_READ4, CMD_FAST3, CMD_FAST4, CMD_QOUT3, CMD_QOUT4:
      begin
        c.has_addr = 1'b1;
        c.rd = 1'b1;
        c.dummy = (op != CMD_READ3) && (op != CMD_READ4);
        c.quad_data = (op == CMD_QOUT3) || (op == CMD_QOUT4);
      end
      CMD_QIO3, CMD_QIO4, CMD_QDDR3, CMD_QDDR4:
      begin
        c.has_addr = 1'b1;
        c.rd = 1'b1;
        c.dummy = 1'b1;
        c.quad_addr = 1'b1;
        c.quad_data = 1'b1;
        c.ddr = (op == CMD_QDDR3) || (op == CMD_QDDR4);
      end
      CMD_PROG3, CMD_PROG4, CMD_QPROG3, CMD_QPROG4, CMD_XQPROG3, CMD_XQPROG4, CMD_WR_VCFG:
      begin
        c.has_addr = 1'b1;
        c.wr = 1'b1;
        c.quad_data = (op != CMD_PROG3) && (op != CMD_PROG4) && (op != CMD_WR_VCFG);
        c.quad_addr = (op == CMD_XQPROG3) || (op == CMD_XQPROG4);
      end
      default:
      begin
        c = '0;
      end
    endcase
    c.addr4 = (op == CMD_READ4) || (op == CMD_FAST4) || (op == CMD_QOUT4) ||
      (op == CMD_QIO4) || (op == CMD_QDDR4) || (op == CMD_PROG4) ||
      (op == CMD_QPROG4) || (op == CMD_XQPROG4);
    return c;
  endfunction

endpackage

// >>> sfb_sync.sv
// two-stage synchroniser for pins entering the clk domain
`timescale 1ns/1ps
`default_nettype none

module sfb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // one synchroniser per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r; // first stage, read only by the second
      logic sync_r; // second stage
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
        end
        else
        begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate

endmodule // sfb_sync

`default_nettype wire

// >>> sfb_ctrl.sv
// serial flash bus front end: command, address, data phases and mode state
// Notes on behaviour
// - works with clock idling low or high
// - sample on rising, shift out on falling
// - quad read and program commands move nibbles
// - quad commands turn io0/io1 bidirectional
// - double-edge quad read drives both edges
// - 38h enters, ffh leaves four-wire mode
// - four-wire mode takes opcode on four lines
// - power-up and 66h+99h give single mode
// - e7h/c7h to byte 0 via 81h
// - double-edge mode opcode on rising edges only
// - double-edge mode address/data on both edges
// - long clear pulse restores volatile defaults
// - clear pin overrides every state
// - flag low per corrected 8-byte group
// - flag pin only drives low
// - strobe enabled by default during reads
// - strobe low on select, toggles with data
// - strobe toggles at serial clock rate
// - strobe disabled leaves pin undriven
// - power-down ignores all but exit and reset
`timescale 1ns/1ps
`default_nettype none

module sfb_ctrl
  import sfb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic clear_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic correction_flag_n_out,
  output logic correction_flag_n_oe,
  input wire logic nv_dqs_disable,
  input wire logic [7:0] rd_byte,
  input wire logic rd_sec,
  output logic rd_next,
  output logic [31:0] addr,
  output logic addr_valid,
  output logic [7:0] wr_byte,
  output logic wr_strobe,
  output logic four_wire_command_mode,
  output logic double_edge_mode,
  output logic deep_power_down
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  sfb_pins_t pins_raw; // pins as they arrive
  sfb_pins_t pins_s; // pins in the clk domain
  assign pins_raw = '{cs_n: cs_n, sclk: sclk, clear_n: clear_n, io: io_in};

  sfb_sync #(.W($bits(sfb_pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pins_raw),
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // clear pin low-time counter
  // ----------------------------------------------------------------
  logic [7:0] clr_cnt_r; // cycles the clear pin has been low
  logic [7:0] clr_cnt_nxt;
  logic clear_hit; // clear pin low long enough

  // count low time, saturating at the minimum
  always_comb
  begin
    clear_hit = !pins_s.clear_n && (clr_cnt_r >= MIN_CLEAR_LOW_CYC - 8'd1);
    if (pins_s.clear_n)
      clr_cnt_nxt = 8'h00;
    else if (clr_cnt_r == MIN_CLEAR_LOW_CYC)
      clr_cnt_nxt = clr_cnt_r;
    else
      clr_cnt_nxt = clr_cnt_r + 8'h01;
  end

  // register the counter
  always_ff @(posedge clk)
  begin
    if (srst)
      clr_cnt_r <= 8'h00;
    else
      clr_cnt_r <= clr_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // transfer engine and mode state
  // ----------------------------------------------------------------
  sfb_state_t state_r, state_nxt; // transfer phase
  sfb_cmd_t cmd_r, cmd_nxt; // shape of current command
  logic [7:0] op_r, op_nxt; // current opcode
  logic [31:0] sr_r, sr_nxt; // receive shifter
  logic [5:0] cnt_r, cnt_nxt; // bits or cycles of current phase
  logic [7:0] obyte_r, obyte_nxt; // remainder of byte being sent
  logic [2:0] ocnt_r, ocnt_nxt; // bits of byte already sent
  logic [2:0] grp_r, grp_nxt; // byte within 8-byte group
  logic out_go_r, out_go_nxt; // first output unit has been driven
  logic sclk_prev_r, sclk_prev_nxt; // sclk one cycle ago
  logic four_r, four_nxt; // four-wire command mode
  logic [7:0] vcfg0_r, vcfg0_nxt; // volatile configuration byte 0
  logic ddr_mode_r, ddr_mode_nxt; // double-edge quad mode
  logic pdown_r, pdown_nxt; // deep power-down
  logic rst_en_r, rst_en_nxt; // reset armed by 66h
  logic [3:0] io_out_r, io_out_nxt;
  logic [3:0] io_oe_r, io_oe_nxt;
  logic dqs_r, dqs_nxt;
  logic dqs_oe_r, dqs_oe_nxt;
  logic ecs_oe_r, ecs_oe_nxt; // pulls correction flag low
  logic rd_next_r, rd_next_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic addr_valid_r, addr_valid_nxt;
  logic [7:0] wr_byte_r, wr_byte_nxt;
  logic wr_strobe_r, wr_strobe_nxt;
  logic rise, fall; // sclk edges seen in clk domain
  logic cap_quad, cap_edge, oedge; // lane width and capture moments
  logic [31:0] sr_shift; // shifter with the new unit taken
  logic [5:0] cnt_inc; // bit count after the new unit
  logic cmd_done; // opcode complete this cycle
  logic [7:0] cmd_op; // opcode being completed
  logic dqs_enable; // strobe function on
  sfb_cmd_t dec;
  logic [7:0] byte_v;

  assign rise = pins_s.sclk && !sclk_prev_r;
  assign fall = !pins_s.sclk && sclk_prev_r;
  assign dqs_enable = !nv_dqs_disable && vcfg0_r[DQS_EN_BIT];

  // next-state logic for the whole transfer
  always_comb
  begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    op_nxt = op_r;
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    obyte_nxt = obyte_r;
    ocnt_nxt = ocnt_r;
    grp_nxt = grp_r;
    out_go_nxt = out_go_r;
    sclk_prev_nxt = pins_s.sclk;
    four_nxt = four_r;
    vcfg0_nxt = vcfg0_r;
    pdown_nxt = pdown_r;
    rst_en_nxt = rst_en_r;
    io_out_nxt = io_out_r;
    io_oe_nxt = io_oe_r;
    ecs_oe_nxt = ecs_oe_r;
    addr_nxt = addr_r;
    wr_byte_nxt = wr_byte_r;
    rd_next_nxt = 1'b0;
    addr_valid_nxt = 1'b0;
    wr_strobe_nxt = 1'b0;
    cmd_done = 1'b0;
    dec = '0;
    byte_v = obyte_r;
    // lane width and capture edge per phase
    case (state_r)
      ST_CMD:
      begin
        cap_quad = four_r || ddr_mode_r;
        cap_edge = rise;
      end
      ST_ADDR:
      begin
        cap_quad = cmd_r.quad_addr;
        // double-edge address opens on the rise after the opcode, not the fall before it
        cap_edge = rise || (cmd_r.ddr && fall && cnt_r != 6'd0);
      end
      ST_IN:
      begin
        cap_quad = cmd_r.quad_data;
        cap_edge = rise || (cmd_r.ddr && fall);
      end
      default:
      begin
        cap_quad = 1'b0;
        cap_edge = 1'b0;
      end
    endcase
    // double-edge data opens on a rise, so the first strobe rise marks the first unit
    oedge = cmd_r.ddr ? (rise || (fall && out_go_r)) : fall;
    sr_shift = cap_quad ? {sr_r[27:0], pins_s.io} : {sr_r[30:0], pins_s.io[0]};
    cnt_inc = cnt_r + (cap_quad ? 6'd4 : 6'd1);
    cmd_op = sr_shift[7:0];
    if (!pins_s.cs_n)
    begin
      case (state_r)
        // opcode collection
        ST_CMD:
        begin
          if (cap_edge)
          begin
            sr_nxt = sr_shift;
            cnt_nxt = cnt_inc;
            if (cnt_inc == BYTE_BITS)
            begin
              cmd_done = 1'b1;
              cnt_nxt = 6'd0;
              op_nxt = cmd_op;
              state_nxt = ST_IGNORE;
              rst_en_nxt = 1'b0;
              dec = sfb_decode(cmd_op);
              if (!pdown_r || cmd_op == CMD_PDOWN_EXIT || cmd_op == CMD_RST_EN ||
                cmd_op == CMD_RST)
              begin
                case (cmd_op)
                  CMD_RST_EN: rst_en_nxt = 1'b1;
                  CMD_RST:
                  begin
                    if (rst_en_r)
                    begin
                      four_nxt = 1'b0;
                      vcfg0_nxt = VCFG0_RST;
                      pdown_nxt = 1'b0;
                    end
                  end
                  CMD_FOUR_ON: four_nxt = 1'b1;
                  CMD_FOUR_OFF: four_nxt = 1'b0;
                  CMD_PDOWN: pdown_nxt = 1'b1;
                  CMD_PDOWN_EXIT: pdown_nxt = 1'b0;
                  default:
                  begin
                    if (dec.has_addr)
                    begin
                      cmd_nxt = dec;
                      cmd_nxt.quad_addr = dec.quad_addr || four_r || ddr_mode_r;
                      cmd_nxt.quad_data = dec.quad_data || four_r || ddr_mode_r;
                      cmd_nxt.ddr = dec.ddr || ddr_mode_r;
                      state_nxt = ST_ADDR;
                    end
                  end
                endcase
              end
            end
          end
        end
        // address collection
        ST_ADDR:
        begin
          if (cap_edge)
          begin
            sr_nxt = sr_shift;
            cnt_nxt = cnt_inc;
            if (cnt_inc == (cmd_r.addr4 ? ADDR4_BITS : ADDR3_BITS))
            begin
              cnt_nxt = 6'd0;
              addr_nxt = cmd_r.addr4 ? sr_shift : {8'h00, sr_shift[23:0]};
              addr_valid_nxt = 1'b1;
              if (cmd_r.dummy)
                state_nxt = ST_DUMMY;
              else if (cmd_r.rd)
                state_nxt = ST_OUT;
              else
                state_nxt = ST_IN;
            end
          end
        end
        // dummy clocks before read data
        ST_DUMMY:
        begin
          if (rise)
          begin
            cnt_nxt = cnt_r + 6'd1;
            if (cnt_r + 6'd1 == DUMMY_CYC)
            begin
              cnt_nxt = 6'd0;
              state_nxt = ST_OUT;
            end
          end
        end
        // read data out
        ST_OUT:
        begin
          if (oedge)
          begin
            out_go_nxt = 1'b1;
            if (ocnt_r == 3'd0)
            begin
              byte_v = rd_byte;
              rd_next_nxt = 1'b1;
              grp_nxt = grp_r + 3'd1;
              if (grp_r == 3'd0)
                ecs_oe_nxt = rd_sec;
            end
            if (cmd_r.quad_data)
            begin
              io_out_nxt = byte_v[7:4];
              obyte_nxt = {byte_v[3:0], 4'h0};
              ocnt_nxt = ocnt_r + 3'd4;
              io_oe_nxt = 4'hf;
            end
            else
            begin
              io_out_nxt = {2'b00, byte_v[7], 1'b0};
              obyte_nxt = {byte_v[6:0], 1'b0};
              ocnt_nxt = ocnt_r + 3'd1;
              io_oe_nxt = 4'b0010;
            end
          end
        end
        // write data in
        ST_IN:
        begin
          if (cap_edge)
          begin
            sr_nxt = sr_shift;
            cnt_nxt = cnt_inc;
            if (cnt_inc == BYTE_BITS)
            begin
              cnt_nxt = 6'd0;
              if (op_r == CMD_WR_VCFG)
              begin
                if (addr_r == 32'h0000_0000)
                  vcfg0_nxt = sr_shift[7:0];
                state_nxt = ST_IGNORE;
              end
              else
              begin
                wr_byte_nxt = sr_shift[7:0];
                wr_strobe_nxt = 1'b1;
              end
            end
          end
        end
        ST_IGNORE:
        begin
          state_nxt = ST_IGNORE;
        end
        default:
        begin
          state_nxt = ST_CMD;
        end
      endcase
    end
    else
    begin
      // deselected: drop partial command, release lines
      state_nxt = ST_CMD;
      cnt_nxt = 6'd0;
      ocnt_nxt = 3'd0;
      grp_nxt = 3'd0;
      out_go_nxt = 1'b0;
      io_oe_nxt = 4'h0;
      ecs_oe_nxt = 1'b0;
    end
    // hardware clear overrides everything
    if (clear_hit)
    begin
      state_nxt = ST_CMD;
      cnt_nxt = 6'd0;
      ocnt_nxt = 3'd0;
      grp_nxt = 3'd0;
      out_go_nxt = 1'b0;
      four_nxt = 1'b0;
      vcfg0_nxt = VCFG0_RST;
      pdown_nxt = 1'b0;
      rst_en_nxt = 1'b0;
      io_oe_nxt = 4'h0;
      ecs_oe_nxt = 1'b0;
      rd_next_nxt = 1'b0;
      wr_strobe_nxt = 1'b0;
      addr_valid_nxt = 1'b0;
    end
    ddr_mode_nxt = (vcfg0_nxt == VCFG0_DDR_A) || (vcfg0_nxt == VCFG0_DDR_B);
    dqs_oe_nxt = !pins_s.cs_n && dqs_enable;
    dqs_nxt = out_go_nxt && pins_s.sclk;
  end

  // register the transfer state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_CMD;
      cmd_r <= '0;
      op_r <= 8'h00;
      sr_r <= 32'h0000_0000;
      cnt_r <= 6'd0;
      obyte_r <= 8'h00;
      ocnt_r <= 3'd0;
      grp_r <= 3'd0;
      out_go_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      four_r <= 1'b0;
      vcfg0_r <= VCFG0_RST;
      ddr_mode_r <= 1'b0;
      pdown_r <= 1'b0;
      rst_en_r <= 1'b0;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
      dqs_r <= 1'b0;
      dqs_oe_r <= 1'b0;
      ecs_oe_r <= 1'b0;
      rd_next_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      addr_valid_r <= 1'b0;
      wr_byte_r <= 8'h00;
      wr_strobe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      op_r <= op_nxt;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      obyte_r <= obyte_nxt;
      ocnt_r <= ocnt_nxt;
      grp_r <= grp_nxt;
      out_go_r <= out_go_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      four_r <= four_nxt;
      vcfg0_r <= vcfg0_nxt;
      ddr_mode_r <= ddr_mode_nxt;
      pdown_r <= pdown_nxt;
      rst_en_r <= rst_en_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r <= io_oe_nxt;
      dqs_r <= dqs_nxt;
      dqs_oe_r <= dqs_oe_nxt;
      ecs_oe_r <= ecs_oe_nxt;
      rd_next_r <= rd_next_nxt;
      addr_r <= addr_nxt;
      addr_valid_r <= addr_valid_nxt;
      wr_byte_r <= wr_byte_nxt;
      wr_strobe_r <= wr_strobe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_out = io_out_r;
  assign io_oe = io_oe_r;
  assign dqs_out = dqs_r;
  assign dqs_oe = dqs_oe_r;
  assign correction_flag_n_out = 1'b0;
  assign correction_flag_n_oe = ecs_oe_r;
  assign rd_next = rd_next_r;
  assign addr = addr_r;
  assign addr_valid = addr_valid_r;
  assign wr_byte = wr_byte_r;
  assign wr_strobe = wr_strobe_r;
  assign four_wire_command_mode = four_r;
  assign double_edge_mode = ddr_mode_r;
  assign deep_power_down = pdown_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  deselect_release_a: assert property (pins_s.cs_n |=> io_oe_r == 4'h0)
    else $error("io lines driven while deselected");
  four_enter_a: assert property (cmd_done && cmd_op == CMD_FOUR_ON && !pdown_r && !clear_hit
    |=> four_r)
    else $error("four-wire mode not entered");
  four_leave_a: assert property (cmd_done && cmd_op == CMD_FOUR_OFF && !pdown_r && !clear_hit
    |=> !four_r)
    else $error("four-wire mode not left");
  soft_reset_a: assert property (cmd_done && cmd_op == CMD_RST && rst_en_r && !clear_hit
    |=> !four_r && vcfg0_r == VCFG0_RST)
    else $error("soft reset left volatile state");
  pdown_ignore_a: assert property (cmd_done && pdown_r && !clear_hit && cmd_op != CMD_PDOWN_EXIT
    && cmd_op != CMD_RST_EN && cmd_op != CMD_RST |=> state_r == ST_IGNORE && pdown_r)
    else $error("command accepted in power-down");
  hw_clear_a: assert property (clear_hit |=> !four_r && !pdown_r && vcfg0_r == VCFG0_RST
    && state_r == ST_CMD && io_oe_r == 4'h0)
    else $error("clear pin did not restore defaults");
  ecs_group_a: assert property (
    ecs_oe_r |-> state_r == ST_OUT && correction_flag_n_out == 1'b0)
    else $error("correction flag outside read data");
  dqs_select_a: assert property (!pins_s.cs_n && dqs_enable |=> dqs_oe_r)
    else $error("strobe not driven while selected");
  dqs_off_a: assert property (!dqs_enable |=> !dqs_oe_r)
    else $error("strobe driven while disabled");
  dqs_quiet_a: assert property (!out_go_nxt |=> !dqs_r)
    else $error("strobe toggled before data");
  dqs_follow_a: assert property (out_go_nxt |=> dqs_r == $past(pins_s.sclk))
    else $error("strobe not following serial clock");
  sdr_change_a: assert property ($changed(io_out_r) && !cmd_r.ddr |-> $past(fall))
    else $error("single-edge data changed off a falling edge");
  ddr_change_a: assert property ($changed(io_out_r) && cmd_r.ddr |-> $past(rise || fall))
    else $error("double-edge data changed off a clock edge");
  quad_lanes_a: assert property (state_r == ST_OUT && cmd_r.quad_data && io_oe_r != 4'h0
    |-> io_oe_r == 4'hf)
    else $error("quad read not on four lanes");

endmodule // sfb_ctrl

`default_nettype wire

// >>> sfb_host.sv
// host model: drives select, serial clock and io lines
`timescale 1ns/1ps
`default_nettype none

module sfb_host (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io,
  input wire logic [3:0] io_pin,
  input wire logic dqs
);
  logic [7:0] got; // read data caught on strobe edges
  bit quad_rd = 1'b0; // read data comes on four lines
  bit ddr_rd = 1'b0; // read data on both strobe edges

  // latch read data a little after each strobe rise, or after each strobe edge when ddr_rd is set
  always @(dqs)
    if (!cs_n && (dqs || ddr_rd))
    begin
      #20;
      got = quad_rd ? {got[3:0], io_pin} : {got[6:0], io_pin[1]};
    end

  // idle: deselected, clock low (mode 0)
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    io = 4'hf;
  end

  // msb first, one or four bits per clock, or per edge when d is set
  task automatic xfer(input logic [31:0] v, input int n, input bit q, input bit d = 1'b0);
    for (int i = n - 1; i >= 0; i = i - (q ? 4 : 1))
    begin
      io = q ? v[i -: 4] : {3'h7, v[i]};
      if (d)
      begin
        #31.25 sclk = ~sclk;
        #31.25;
      end
      else
      begin
        #62.5 sclk = 1'h1;
        #62.5 sclk = 1'h0;
      end
    end
  endtask

  // select, settle
  task automatic open();
    #40 cs_n = 1'h0;
    #40;
  endtask

  // deselect, show stale lines inverted, let the device see it
  task automatic close();
    #40 cs_n = 1'h1;
    io = ~io;
    #100;
  endtask
endmodule // sfb_host

`default_nettype wire

// >>> tb_sfb_ctrl.sv
// self-checking bench for the serial flash bus front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_sfb_ctrl;
  import sfb_pkg::*;
  logic clk, srst, clear_n, nv_dqs_disable, rd_sec, cs_n, sclk;
  logic [3:0] hio, io_out, io_oe, pin;
  logic dqs_out, dqs_oe, cf_out, cf_oe, rd_next, addr_valid, wr_strobe;
  logic fw, de, pd;
  logic [7:0] rd_byte, wr_byte;
  logic [31:0] addr;
  int err_count = 0;
  int num_checks = 0;
  int n_av = 0;
  int n_rn = 0;
  int n_ws = 0;
  // opcode, sent on four lines, expected mode flags
  typedef struct packed {logic [7:0] op; logic q; logic fw; logic pd;} sfb_row_t;
  sfb_row_t rows [8] = '{'{8'hb9, 1'h0, 1'h0, 1'h1}, '{8'h38, 1'h0, 1'h0, 1'h1},
    '{8'hab, 1'h0, 1'h0, 1'h0}, '{8'h38, 1'h0, 1'h1, 1'h0}, '{8'hff, 1'h1, 1'h0, 1'h0},
    '{8'h38, 1'h0, 1'h1, 1'h0}, '{8'h66, 1'h1, 1'h1, 1'h0}, '{8'h99, 1'h1, 1'h0, 1'h0}};

  // wire level: device wins where it drives
  assign pin = (io_oe & io_out) | (~io_oe & hio);

  sfb_host host (.cs_n(cs_n), .sclk(sclk), .io(hio), .io_pin(pin), .dqs(dqs_out));

  // one-cycle pulses counted at each rising clk edge
  always @(posedge clk)
  begin
    if (addr_valid) n_av++;
    if (rd_next) n_rn++;
    if (wr_strobe) n_ws++;
  end

  sfb_ctrl uut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .clear_n(clear_n),
    .io_in(pin), .io_out(io_out), .io_oe(io_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .correction_flag_n_out(cf_out), .correction_flag_n_oe(cf_oe),
    .nv_dqs_disable(nv_dqs_disable), .rd_byte(rd_byte), .rd_sec(rd_sec),
    .rd_next(rd_next), .addr(addr), .addr_valid(addr_valid), .wr_byte(wr_byte),
    .wr_strobe(wr_strobe), .four_wire_command_mode(fw), .double_edge_mode(de),
    .deep_power_down(pd));

  // 250 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // verdict and end of run
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    srst = 1'h1;
    clear_n = 1'h1;
    nv_dqs_disable = 1'h0;
    rd_byte = 8'ha5;
    rd_sec = 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    repeat (4) @(posedge clk);
    `CHK("fw0", 1'h0, fw)
    `CHK("oe0", 4'h0, io_oe)
    // mode commands, power-down filtering
    foreach (rows[i])
    begin
      host.open();
      host.xfer(32'(rows[i].op), 8, rows[i].q);
      host.close();
      `CHK("fw", rows[i].fw, fw)
      `CHK("pd", rows[i].pd, pd)
    end
    // single-wire read with strobe and flag
    host.open();
    `CHK("dqs_oe", 1'h1, dqs_oe)
    `CHK("dqs", 1'h0, dqs_out)
    host.xfer(32'h03, 8, 1'b0);
    host.xfer(32'h123456, 24, 1'b0);
    `CHK("addr", 32'h123456, addr)
    host.xfer(32'h0, 8, 1'b0);
    `CHK("data", 8'ha5, host.got)
    `CHK("flag", 1'h1, cf_oe)
    `CHK("flag_lvl", 1'h0, cf_out)
    host.close();
    `CHK("rel", 4'h0, io_oe)
    // quad output read, then quad program
    host.quad_rd = 1'b1;
    host.open();
    host.xfer(32'h6b, 8, 1'b0);
    host.xfer(32'h123456, 24, 1'b0);
    host.xfer(32'h0, 8, 1'b0);
    host.xfer(32'h0, 8, 1'b1);
    `CHK("q_data", 8'ha5, host.got)
    `CHK("q_oe", 4'hf, io_oe)
    host.close();
    host.open();
    host.xfer(32'h32, 8, 1'b0);
    host.xfer(32'h123456, 24, 1'b0);
    host.xfer(32'h3c, 8, 1'b1);
    host.close();
    `CHK("wr", 8'h3c, wr_byte)
    // strobe disabled by nonvolatile bit
    @(posedge clk) nv_dqs_disable <= 1'h1;
    host.open();
    `CHK("dqs_off", 1'h0, dqs_oe)
    host.close();
    @(posedge clk) nv_dqs_disable <= 1'h0;
    // double-edge mode via byte 0, then hardware clear
    host.open();
    host.xfer(32'h81, 8, 1'b0);
    host.xfer(32'h0, 24, 1'b0);
    host.xfer(32'he7, 8, 1'b0);
    host.close();
    `CHK("de", 1'h1, de)
    // double-edge read: opcode on rises, address and data on both edges
    host.ddr_rd = 1'b1;
    host.open();
    host.xfer(32'hed, 8, 1'b1);
    host.xfer(32'h654321, 24, 1'b1, 1'b1);
    host.xfer(32'h0, 8, 1'b0);
    `CHK("d_addr", 32'h654321, addr)
    host.xfer(32'h0, 8, 1'b1, 1'b1);
    host.close();
    `CHK("d_data", 8'ha5, host.got)
    `CHK("n_av", 5, n_av)
    `CHK("n_rn", 5, n_rn)
    `CHK("n_ws", 1, n_ws)
    @(posedge clk) clear_n <= 1'h0;
    repeat (30) @(posedge clk);
    clear_n <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK("de_clr", 1'h0, de)
    give_verdict();
  end
endmodule // tb_sfb_ctrl

`default_nettype wire
